// ### aemc_regs.svh
// Constants for the absolute encoder multiturn controller: reset values and timing counts.
// Assumes a 100 MHz clock; every timing count is derived from its printed time.
`ifndef AEMC_REGS_SVH
`define AEMC_REGS_SVH

`define AEMC_CLK_HZ 100000000
`define AEMC_CYCLES_PER_MS (`AEMC_CLK_HZ / 1000)
`define AEMC_STANDBY_WAIT_MS 100
`define AEMC_ALARM_SETTLE_MS 5000
`define AEMC_BATTERY_WINDOW_MS 4000
`define AEMC_STANDBY_WAIT_CYCLES (`AEMC_STANDBY_WAIT_MS * `AEMC_CYCLES_PER_MS)
`define AEMC_ALARM_SETTLE_CYCLES (`AEMC_ALARM_SETTLE_MS * `AEMC_CYCLES_PER_MS)
`define AEMC_BATTERY_WINDOW_CYCLES (`AEMC_BATTERY_WINDOW_MS * `AEMC_CYCLES_PER_MS)
`define AEMC_TURN_WIDTH 16
`define AEMC_POS_WIDTH 32
`define AEMC_MULTITURN_LIMIT_RESET 16'hFFFF
`define AEMC_ORIGIN_OFFSET_RESET 32'h0000_0000
`define AEMC_BATTERY_REPORT_RESET 1'b0
`define AEMC_TURN_SETUP_VALUE 16'h0000

`endif

// ### aemc_pkg.sv
// Types shared by the absolute encoder multiturn controller modules.
// Turn and position widths come from the constants header; the timers are fixed at 32 bits.
`include "aemc_regs.svh"

package aemc_pkg;

  typedef enum logic [1:0] {
    AEMC_ENC_OFF,
    AEMC_ENC_POWERING,
    AEMC_ENC_READY
  } aemc_enc_state_type;

  typedef struct packed {
    logic [`AEMC_TURN_WIDTH-1:0] count;
  } aemc_turn_state_type;

  typedef struct packed {
    aemc_enc_state_type enc_state;
    logic [31:0] wait_timer;
    logic [31:0] life_timer;
    logic latched;
    logic battery_mode_warning;
    logic [`AEMC_TURN_WIDTH-1:0] limit_cfg;
    logic [`AEMC_TURN_WIDTH-1:0] encoder_limit;
    logic battery_sync1;
    logic battery_sync2;
    logic phase_a_sync1;
    logic phase_a_sync2;
    logic phase_b_sync1;
    logic phase_b_sync2;
    logic origin_sync1;
    logic origin_sync2;
    logic motor_on;
    logic encoder_powered;
    logic serial_standby;
    logic counter_cleared;
    logic [`AEMC_POS_WIDTH-1:0] pulse_count;
    logic [`AEMC_POS_WIDTH-1:0] machine_position;
    logic battery_alarm;
    logic battery_warning;
    logic backup_alarm;
    logic checksum_alarm;
    logic internal_alarm;
    logic mismatch_alarm;
    logic alarm_out;
    logic limit_write;
    logic phase_a;
    logic phase_b;
    logic origin_pulse;
    logic [`AEMC_TURN_WIDTH-1:0] revolution_count;
  } aemc_ctrl_state_type;

endpackage

// ### aemc_turn_if.sv
// Carrier between the controller and its revolution counter.
// Both ends share the controller clock.
`timescale 1ns/1ps
`default_nettype none
`include "aemc_regs.svh"

interface aemc_turn_if;
  logic step_forward;
  logic step_reverse;
  logic setup;
  logic [`AEMC_TURN_WIDTH-1:0] limit;
  logic [`AEMC_TURN_WIDTH-1:0] count;

  modport ctrl (output step_forward, output step_reverse, output setup, output limit,
    input count);
  modport counter (input step_forward, input step_reverse, input setup, input limit,
    output count);
endinterface

`default_nettype wire

// ### aemc_turn_counter.sv
// Multiturn revolution counter that wraps between zero and the configured limit.
// Assumes at most one of forward or reverse step per enabled cycle; setup wins over both.
`timescale 1ns/1ps
`default_nettype none
`include "aemc_regs.svh"

module aemc_turn_counter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  aemc_turn_if.counter turn
);

  aemc_pkg::aemc_turn_state_type state;
  aemc_pkg::aemc_turn_state_type next_state;

  function automatic logic [`AEMC_TURN_WIDTH-1:0] step_turn(
    input logic [`AEMC_TURN_WIDTH-1:0] count,
    input logic [`AEMC_TURN_WIDTH-1:0] limit,
    input logic forward
  );
    logic [`AEMC_TURN_WIDTH-1:0] result;
    if (forward) begin
      result = (count == limit) ? '0 : count + 1'b1;
    end else begin
      result = (count == '0) ? limit : count - 1'b1;
    end
    return result;
  endfunction

  always_comb begin
    next_state = state;
    if (turn.setup) begin
      next_state.count = `AEMC_TURN_SETUP_VALUE;
    end else if (turn.step_forward) begin
      next_state.count = step_turn(state.count, turn.limit, 1'b1);
    end else if (turn.step_reverse) begin
      next_state.count = step_turn(state.count, turn.limit, 1'b0);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state.count <= `AEMC_TURN_SETUP_VALUE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign turn.count = state.count;

endmodule

`default_nettype wire

// ### aemc_ctrl.sv
// Absolute encoder management inside a servo drive: encoder power-on, alarms,
// multiturn counting, origin offset and the encoder-emulation outputs.
// Assumes command inputs are one-cycle pulses from same-clock logic; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "aemc_regs.svh"

module aemc_ctrl #(
  parameter logic [31:0] STANDBY_WAIT_CYCLES = `AEMC_STANDBY_WAIT_CYCLES,
  parameter logic [31:0] ALARM_SETTLE_CYCLES = `AEMC_ALARM_SETTLE_CYCLES,
  parameter logic [31:0] BATTERY_WINDOW_CYCLES = `AEMC_BATTERY_WINDOW_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic encoder_power_on_cmd,
  input wire logic encoder_power_off_cmd,
  input wire logic motor_energise_cmd,
  input wire logic motor_release_cmd,
  input wire logic generic_alarm_clear_cmd,
  input wire logic encoder_setup_cmd,
  input wire logic limit_write_cmd,
  input wire logic battery_report_select,
  input wire logic [`AEMC_TURN_WIDTH-1:0] multiturn_limit_setting,
  input wire logic [`AEMC_TURN_WIDTH-1:0] encoder_stored_limit,
  input wire logic [`AEMC_POS_WIDTH-1:0] origin_offset_setting,
  input wire logic [`AEMC_POS_WIDTH-1:0] encoder_position,
  input wire logic battery_low_pin,
  input wire logic backup_error_event,
  input wire logic checksum_error_event,
  input wire logic internal_error_event,
  input wire logic pulse_step_forward,
  input wire logic pulse_step_reverse,
  input wire logic turn_step_forward,
  input wire logic turn_step_reverse,
  input wire logic phase_a_pin,
  input wire logic phase_b_pin,
  input wire logic origin_pin,
  input wire logic serial_tx_active,
  input wire logic serial_tx_bit,
  output logic encoder_powered,
  output logic serial_standby,
  output logic motor_energised,
  output logic battery_alarm,
  output logic battery_warning,
  output logic backup_alarm,
  output logic checksum_alarm,
  output logic internal_alarm,
  output logic multiturn_mismatch_alarm_code,
  output logic alarm_output,
  output logic encoder_limit_write,
  output logic [`AEMC_POS_WIDTH-1:0] pulse_count,
  output logic [`AEMC_POS_WIDTH-1:0] machine_coordinate_position,
  output logic [`AEMC_TURN_WIDTH-1:0] revolution_count,
  output logic phase_a_output,
  output logic phase_b_output,
  output logic origin_pulse_output
);

  aemc_pkg::aemc_ctrl_state_type state;
  aemc_pkg::aemc_ctrl_state_type next_state;
  aemc_turn_if turn ();
  logic settled;
  logic battery_armed;
  logic any_alarm;
  logic [`AEMC_POS_WIDTH-1:0] offset_in_use;

  aemc_turn_counter u_turn (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .turn(turn)
  );

  // The life timer stands in for time since control power-on; it saturates at the
  // end of the alarm-mode window so it never wraps and re-arms detection.
  always_comb begin
    settled = state.life_timer >= ALARM_SETTLE_CYCLES;
    if (state.battery_mode_warning) begin
      battery_armed = settled;
    end else begin
      battery_armed = settled && (state.life_timer < ALARM_SETTLE_CYCLES +
        BATTERY_WINDOW_CYCLES);
    end
    any_alarm = state.battery_alarm | state.backup_alarm | state.checksum_alarm |
      state.internal_alarm | state.mismatch_alarm;
    offset_in_use = state.encoder_powered ? origin_offset_setting :
      `AEMC_ORIGIN_OFFSET_RESET;
    turn.step_forward = state.latched & turn_step_forward;
    turn.step_reverse = state.latched & turn_step_reverse;
    turn.setup = state.latched & encoder_setup_cmd & ~state.motor_on;
    turn.limit = state.limit_cfg;
  end

  always_comb begin
    next_state = state;
    next_state.battery_sync1 = battery_low_pin;
    next_state.battery_sync2 = state.battery_sync1;
    next_state.phase_a_sync1 = phase_a_pin;
    next_state.phase_a_sync2 = state.phase_a_sync1;
    next_state.phase_b_sync1 = phase_b_pin;
    next_state.phase_b_sync2 = state.phase_b_sync1;
    next_state.origin_sync1 = origin_pin;
    next_state.origin_sync2 = state.origin_sync1;
    next_state.counter_cleared = 1'b0;
    next_state.limit_write = 1'b0;
    if (state.life_timer < ALARM_SETTLE_CYCLES + BATTERY_WINDOW_CYCLES) begin
      next_state.life_timer = state.life_timer + 32'h0000_0001;
    end
    // Restart-only settings are caught once, on the first enabled cycle after reset.
    if (!state.latched) begin
      next_state.latched = 1'b1;
      next_state.battery_mode_warning = battery_report_select;
      next_state.limit_cfg = multiturn_limit_setting;
      next_state.encoder_limit = encoder_stored_limit;
    end
    case (state.enc_state)
      aemc_pkg::AEMC_ENC_OFF: begin
        if (encoder_power_on_cmd) begin
          next_state.enc_state = aemc_pkg::AEMC_ENC_POWERING;
          next_state.wait_timer = '0;
          next_state.encoder_powered = 1'b1;
        end
      end
      aemc_pkg::AEMC_ENC_POWERING: begin
        if (state.wait_timer >= STANDBY_WAIT_CYCLES - 32'h0000_0001) begin
          next_state.enc_state = aemc_pkg::AEMC_ENC_READY;
          next_state.serial_standby = 1'b1;
          next_state.counter_cleared = 1'b1;
        end else begin
          next_state.wait_timer = state.wait_timer + 32'h0000_0001;
        end
      end
      aemc_pkg::AEMC_ENC_READY: begin
        if (serial_tx_active) begin
          next_state.serial_standby = 1'b0;
        end
      end
      default: begin
        next_state.enc_state = aemc_pkg::AEMC_ENC_OFF;
      end
    endcase
    if (encoder_power_off_cmd) begin
      next_state.enc_state = aemc_pkg::AEMC_ENC_OFF;
      next_state.encoder_powered = 1'b0;
      next_state.serial_standby = 1'b0;
    end
    if (state.counter_cleared) begin
      next_state.pulse_count = '0;
    end else if (pulse_step_forward & ~pulse_step_reverse) begin
      next_state.pulse_count = state.pulse_count + 32'h0000_0001;
    end else if (pulse_step_reverse & ~pulse_step_forward) begin
      next_state.pulse_count = state.pulse_count - 32'h0000_0001;
    end
    // Energise is refused while powering up or under any alarm; an alarm also drops it.
    if (motor_release_cmd || any_alarm) begin
      next_state.motor_on = 1'b0;
    end else if (motor_energise_cmd && state.enc_state != aemc_pkg::AEMC_ENC_POWERING) begin
      next_state.motor_on = 1'b1;
    end
    if (generic_alarm_clear_cmd) begin
      next_state.battery_warning = 1'b0;
    end
    if (battery_armed && state.battery_sync2) begin
      if (state.battery_mode_warning) begin
        next_state.battery_warning = 1'b1;
      end else begin
        next_state.battery_alarm = 1'b1;
      end
    end
    // Setup clears backup and checksum alarms only with the motor off; a new event wins.
    if (turn.setup) begin
      next_state.backup_alarm = 1'b0;
      next_state.checksum_alarm = 1'b0;
    end
    if (backup_error_event) begin
      next_state.backup_alarm = 1'b1;
    end
    if (checksum_error_event) begin
      next_state.checksum_alarm = 1'b1;
    end
    if (internal_error_event) begin
      next_state.internal_alarm = 1'b1;
    end
    if (state.latched && limit_write_cmd && !state.motor_on) begin
      next_state.encoder_limit = state.limit_cfg;
      next_state.limit_write = 1'b1;
    end
    next_state.mismatch_alarm = state.latched && (state.encoder_limit != state.limit_cfg);
    next_state.alarm_out = ~settled | any_alarm;
    next_state.machine_position = encoder_position - offset_in_use;
    next_state.revolution_count = turn.count;
    if (state.encoder_powered) begin
      next_state.phase_a = serial_tx_active ? serial_tx_bit : state.phase_a_sync2;
      next_state.phase_b = state.phase_b_sync2;
      next_state.origin_pulse = state.origin_sync2;
    end else begin
      next_state.phase_a = 1'b0;
      next_state.phase_b = 1'b0;
      next_state.origin_pulse = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= '0;
      state.enc_state <= aemc_pkg::AEMC_ENC_OFF;
      state.battery_mode_warning <= `AEMC_BATTERY_REPORT_RESET;
      state.limit_cfg <= `AEMC_MULTITURN_LIMIT_RESET;
      state.encoder_limit <= `AEMC_MULTITURN_LIMIT_RESET;
      state.alarm_out <= 1'b1;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign encoder_powered = state.encoder_powered;
  assign serial_standby = state.serial_standby;
  assign motor_energised = state.motor_on;
  assign battery_alarm = state.battery_alarm;
  assign battery_warning = state.battery_warning;
  assign backup_alarm = state.backup_alarm;
  assign checksum_alarm = state.checksum_alarm;
  assign internal_alarm = state.internal_alarm;
  assign multiturn_mismatch_alarm_code = state.mismatch_alarm;
  assign alarm_output = state.alarm_out;
  assign encoder_limit_write = state.limit_write;
  assign pulse_count = state.pulse_count;
  assign machine_coordinate_position = state.machine_position;
  assign revolution_count = state.revolution_count;
  assign phase_a_output = state.phase_a;
  assign phase_b_output = state.phase_b;
  assign origin_pulse_output = state.origin_pulse;

endmodule

`default_nettype wire

// ### aemc_ctrl_monitor.sv
// Checker on the encoder controller ports: power-on, alarms, turn wrap and position.
// Bound into aemc_ctrl; checks pause while reset is asserted or the clock enable is low.
`timescale 1ns/1ps
`default_nettype none
`include "aemc_regs.svh"
module aemc_ctrl_monitor #(
  parameter logic [31:0] STANDBY_WAIT_CYCLES = 32'h0000_0014,
  parameter logic [31:0] ALARM_SETTLE_CYCLES = 32'h0000_0032,
  parameter logic [31:0] BATTERY_WINDOW_CYCLES = 32'h0000_0028
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic encoder_power_on_cmd,
  input wire logic encoder_power_off_cmd,
  input wire logic encoder_setup_cmd,
  input wire logic backup_error_event,
  input wire logic turn_step_forward,
  input wire logic turn_step_reverse,
  input wire logic [`AEMC_TURN_WIDTH-1:0] multiturn_limit_setting,
  input wire logic [`AEMC_POS_WIDTH-1:0] encoder_position,
  input wire logic [`AEMC_POS_WIDTH-1:0] origin_offset_setting,
  input wire logic encoder_powered,
  input wire logic serial_standby,
  input wire logic motor_energised,
  input wire logic battery_alarm,
  input wire logic backup_alarm,
  input wire logic multiturn_mismatch_alarm_code,
  input wire logic alarm_output,
  input wire logic [`AEMC_POS_WIDTH-1:0] pulse_count,
  input wire logic [`AEMC_POS_WIDTH-1:0] machine_coordinate_position,
  input wire logic [`AEMC_TURN_WIDTH-1:0] revolution_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);
  localparam int SW1 = STANDBY_WAIT_CYCLES + 1;
  // A few cycles of slack cover the battery pin synchroniser and the alarm register.
  localparam int WLO = ALARM_SETTLE_CYCLES;
  localparam int WHI = ALARM_SETTLE_CYCLES + BATTERY_WINDOW_CYCLES + 4;
  logic [15:0] life;
  logic powering;
  logic quiet;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      life <= 16'h0000;
      powering <= 1'b0;
      quiet <= 1'b0;
    end else if (ce) begin
      life <= (life == 16'hFFFF) ? life : life + 16'h0001;
      quiet <= !(turn_step_forward || turn_step_reverse || encoder_setup_cmd);
      if (encoder_power_off_cmd || serial_standby) begin
        powering <= 1'b0;
      end else if (encoder_power_on_cmd && !encoder_powered && life != 16'h0000) begin
        powering <= 1'b1;
      end
    end
  end
  sequence s_on_taken;
    encoder_power_on_cmd && !encoder_power_off_cmd && !encoder_powered && life != 16'h0000;
  endsequence
  sequence s_standby_then_clear;
    ##SW1 serial_standby ##1 (pulse_count == 32'h0000_0000);
  endsequence
  property p_wrap(logic step, logic [15:0] from, logic [15:0] to);
    step && quiet && !encoder_setup_cmd && revolution_count == from |-> ##2 revolution_count == to;
  endproperty
  a_power_on_ack: assert property (s_on_taken |=> encoder_powered)
    else $error("power-on not acknowledged");
  a_no_energise_powering: assert property (
    powering && !serial_standby && !encoder_power_off_cmd && !motor_energised |=> !motor_energised)
    else $error("motor energised while encoder powering");
  a_standby_delay: assert property (s_on_taken |-> s_standby_then_clear)
    else $error("standby or pulse clear at wrong time");
  a_mismatch_alarm: assert property (multiturn_mismatch_alarm_code |=> alarm_output)
    else $error("alarm output low during mismatch");
  a_backup_holds: assert property (backup_alarm && !encoder_setup_cmd |=> backup_alarm)
    else $error("backup alarm cleared without setup");
  a_setup_clears: assert property (
    encoder_setup_cmd && !motor_energised && !backup_error_event && life != 16'h0000
    |=> !backup_alarm ##1 revolution_count == 16'h0000) else $error("setup did not reinitialise");
  a_battery_window: assert property ($rose(battery_alarm) |-> life >= WLO && life <= WHI)
    else $error("battery alarm outside detection window");
  a_wrap_reverse: assert property (p_wrap(turn_step_reverse && !turn_step_forward,
    16'h0000, multiturn_limit_setting)) else $error("reverse wrap wrong");
  a_wrap_forward: assert property (p_wrap(turn_step_forward,
    multiturn_limit_setting, 16'h0000)) else $error("forward wrap wrong");
  a_machine_pos: assert property (encoder_powered && !encoder_power_off_cmd |=>
    machine_coordinate_position == $past(encoder_position) - $past(origin_offset_setting))
    else $error("machine position wrong");
endmodule
bind aemc_ctrl aemc_ctrl_monitor #(.STANDBY_WAIT_CYCLES(STANDBY_WAIT_CYCLES),
  .ALARM_SETTLE_CYCLES(ALARM_SETTLE_CYCLES), .BATTERY_WINDOW_CYCLES(BATTERY_WINDOW_CYCLES)
) u_monitor (.clk, .rstn, .ce, .encoder_power_on_cmd, .encoder_power_off_cmd,
  .encoder_setup_cmd, .backup_error_event, .turn_step_forward, .turn_step_reverse,
  .multiturn_limit_setting,
  .encoder_position, .origin_offset_setting, .encoder_powered, .serial_standby, .motor_energised,
  .battery_alarm, .backup_alarm, .multiturn_mismatch_alarm_code, .alarm_output, .pulse_count,
  .machine_coordinate_position, .revolution_count);
`default_nettype wire

// ### aemc_host_model.sv
// Host motion controller model: issues one-cycle commands on the command link.
// Drives 1 ns after the rising edge, so each command is taken at the following edge.
`timescale 1ns/1ps
`default_nettype none
module aemc_host_model (
  input wire logic clk,
  input wire logic motor_energised,
  output logic [6:0] cmd
);
  // Bits: power on, power off, energise, release, clear, setup, limit write.
  logic writes_permitted;
  initial begin
    cmd = 7'h00;
    writes_permitted = 1'b0;
  end
  task automatic permit_writes();
    writes_permitted = 1'b1;
  endtask
  function automatic logic [15:0] gear_limit(input logic [15:0] m);
    return m - 16'h0001;
  endfunction
  task automatic pulse(input int idx);
    // Setup and limit write are withheld while the motor is powered or writes are locked.
    if (idx >= 5 && (motor_energised !== 1'b0 || !writes_permitted)) begin
      return;
    end
    @(posedge clk);
    #1 cmd[idx] = 1'b1;
    @(posedge clk);
    #1 cmd[idx] = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb_aemc_ctrl.sv
// Self-checking bench for the encoder controller with shortened timing counts.
// Needs the design, the checker and the host model compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_aemc_ctrl;
  localparam int ON = 0, OFF = 1, ENG = 2, REL = 3, CLR = 4, SET = 5, LIM = 6;
  logic clk, rstn, sel, bat, bkp_ev, csum_ev, int_ev, pstep, tfwd, trev, pa_pin, pb_pin, pz_pin;
  logic ce, prev, stx_act, stx_bit;
  logic [15:0] lim, enc_lim, turns;
  logic [31:0] offs, epos, pcount, mpos;
  logic [6:0] cmd;
  logic powered, standby, motor_on, bat_alm, bat_warn, bkp_alm, csum_alm, int_alm, mis_alm;
  logic alm_out, lim_wr, pa, pb, pz;
  int err_count = 0;
  int n_checks = 0;
  aemc_host_model host (.clk(clk), .motor_energised(motor_on), .cmd(cmd));
  aemc_ctrl #(.STANDBY_WAIT_CYCLES(32'h0000_0014), .ALARM_SETTLE_CYCLES(32'h0000_0032),
    .BATTERY_WINDOW_CYCLES(32'h0000_0028)) uut (
    .clk(clk), .rstn(rstn), .ce(ce), .encoder_power_on_cmd(cmd[0]),
    .encoder_power_off_cmd(cmd[1]), .motor_energise_cmd(cmd[2]), .motor_release_cmd(cmd[3]),
    .generic_alarm_clear_cmd(cmd[4]), .encoder_setup_cmd(cmd[5]), .limit_write_cmd(cmd[6]),
    .battery_report_select(sel), .multiturn_limit_setting(lim), .encoder_stored_limit(enc_lim),
    .origin_offset_setting(offs), .encoder_position(epos), .battery_low_pin(bat),
    .backup_error_event(bkp_ev), .checksum_error_event(csum_ev), .internal_error_event(int_ev),
    .pulse_step_forward(pstep), .pulse_step_reverse(prev), .turn_step_forward(tfwd),
    .turn_step_reverse(trev), .phase_a_pin(pa_pin), .phase_b_pin(pb_pin), .origin_pin(pz_pin),
    .serial_tx_active(stx_act), .serial_tx_bit(stx_bit), .encoder_powered(powered),
    .serial_standby(standby), .motor_energised(motor_on), .battery_alarm(bat_alm),
    .battery_warning(bat_warn), .backup_alarm(bkp_alm), .checksum_alarm(csum_alm),
    .internal_alarm(int_alm), .multiturn_mismatch_alarm_code(mis_alm), .alarm_output(alm_out),
    .encoder_limit_write(lim_wr), .pulse_count(pcount), .machine_coordinate_position(mpos),
    .revolution_count(turns), .phase_a_output(pa), .phase_b_output(pb), .origin_pulse_output(pz));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict();
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Settings are levels latched only on the first edge after reset, so each change restarts.
  task automatic restart(input logic s, input logic [15:0] l, input logic [15:0] e);
    sel = s;
    lim = l;
    enc_lim = e;
    rstn = 1'b0;
    cyc(6);
    rstn = 1'b1;
  endtask
  task automatic step(input logic fwd);
    tfwd = fwd;
    trev = !fwd;
    cyc(1);
    tfwd = 1'b0;
    trev = 1'b0;
    cyc(2);
  endtask
  // A timeout counts a mismatch and lets the run go on to the verdict.
  task automatic wait_standby();
    int i;
    for (i = 0; i < 100 && standby !== 1'b1; i++) cyc(1);
    if (standby !== 1'b1) begin
      err_count++;
      $display("BAD %0t standby never came", $time);
    end
  endtask
  task automatic t_power();
    pstep = 1'b1;
    host.pulse(ON);
    chk(powered, 1'b1);
    host.pulse(ENG);
    chk(motor_on, 1'b0);
    pstep = 1'b0;
    wait_standby();
    cyc(1);
    chk(pcount, 32'h0000_0000);
    prev = 1'b1;
    cyc(1);
    prev = 1'b0;
    chk(pcount, 32'hFFFF_FFFF);
    host.pulse(ENG);
    chk(motor_on, 1'b1);
    host.pulse(REL);
    chk(motor_on, 1'b0);
    epos = 32'h0000_1234;
    offs = 32'h0000_1234;
    cyc(2);
    chk(mpos, 32'h0000_0000);
    offs = 32'hFFFF_FFFB;
    cyc(2);
    chk(mpos, 32'h0000_1239);
    host.pulse(OFF);
    chk({powered, standby}, 2'h0);
  endtask
  task automatic t_turns();
    step(1'b0);
    chk(turns, 16'h0063);
    step(1'b1);
    chk(turns, 16'h0000);
    step(1'b1);
    chk(turns, 16'h0001);
    ce = 1'b0;
    step(1'b1);
    chk(turns, 16'h0001);
    ce = 1'b1;
  endtask
  task automatic t_alarms();
    {bkp_ev, csum_ev} = 2'h3;
    cyc(1);
    {bkp_ev, csum_ev} = 2'h0;
    host.pulse(CLR);
    chk({bkp_alm, csum_alm}, 2'h3);
    host.pulse(REL);
    host.permit_writes();
    host.pulse(SET);
    chk({bkp_alm, csum_alm}, 2'h0);
    cyc(1);
    chk(turns, 16'h0000);
    int_ev = 1'b1;
    cyc(1);
    int_ev = 1'b0;
    host.pulse(CLR);
    host.pulse(SET);
    chk(int_alm, 1'b1);
    restart(1'b0, lim, enc_lim);
    chk(int_alm, 1'b0);
  endtask
  task automatic t_battery();
    cyc(55);
    bat = 1'b1;
    cyc(5);
    bat = 1'b0;
    chk({bat_alm, bat_warn}, 2'h2);
    restart(1'b0, lim, enc_lim);
    cyc(100);
    bat = 1'b1;
    cyc(5);
    chk(bat_alm, 1'b0);
    restart(1'b1, lim, enc_lim);
    cyc(100);
    chk({bat_alm, bat_warn}, 2'h1);
    bat = 1'b0;
    cyc(3);
    host.pulse(CLR);
    chk(bat_warn, 1'b0);
  endtask
  task automatic t_mismatch();
    restart(1'b0, lim, 16'h0032);
    cyc(60);
    chk({mis_alm, alm_out}, 2'h3);
    host.pulse(LIM);
    chk(lim_wr, 1'b1);
    cyc(3);
    chk({mis_alm, alm_out}, 2'h0);
  endtask
  task automatic t_phase();
    {pa_pin, pb_pin, pz_pin} = 3'h7;
    cyc(4);
    chk({pa, pb, pz}, 3'h0);
    host.pulse(ON);
    {pa_pin, pb_pin, pz_pin} = 3'h3;
    cyc(4);
    chk({pa, pb, pz}, 3'h3);
    {pa_pin, pb_pin, pz_pin} = 3'h4;
    cyc(4);
    chk({pa, pb, pz}, 3'h4);
    wait_standby();
    {stx_act, stx_bit, pa_pin} = 3'h6;
    cyc(1);
    chk({standby, pa}, 2'h1);
    {stx_act, stx_bit} = 2'h0;
    cyc(2);
    chk(pa, 1'b0);
  endtask
  initial begin
    {rstn, sel, bat, bkp_ev, csum_ev, int_ev, pstep, tfwd, trev, pa_pin, pb_pin, pz_pin} = 12'h000;
    {lim, enc_lim, offs, epos} = 96'h0;
    {ce, prev, stx_act, stx_bit} = 4'h8;
    restart(1'b0, host.gear_limit(16'h0064), host.gear_limit(16'h0064));
    t_power();
    t_turns();
    t_alarms();
    t_battery();
    t_mismatch();
    t_phase();
    give_verdict();
  end
endmodule
`default_nettype wire
